// ---- hdl/rca_defines.svh ----
/*
  register offsets, field positions, reset values and timing counts of the
  calibration, alarm and watchdog support block.
  assumes it is included by bare name from the design modules.
*/
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH

// register offsets (register address pointer values)
`define RCA_ADDR_CTRL 5'h08
`define RCA_ADDR_WDOG 5'h09
`define RCA_ADDR_AL_MON 5'h0A
`define RCA_ADDR_AL_DATE 5'h0B
`define RCA_ADDR_AL_HOUR 5'h0C
`define RCA_ADDR_AL_MIN 5'h0D
`define RCA_ADDR_AL_SEC 5'h0E
`define RCA_ADDR_FLAGS 5'h0F

// control register fields
`define RCA_CTRL_OUT 7
`define RCA_CTRL_FT 6
`define RCA_CTRL_SIGN 5
`define RCA_CTRL_CAL_HI 4
`define RCA_CTRL_RESET 8'h80

// alarm month register fields
`define RCA_AL_AFE 7
`define RCA_AL_SQUARE_WAVE_ENABLE 6
`define RCA_AL_ABE 5

// repeat bit position in alarm registers (RPT5 sits at bit 6 of alarm date)
`define RCA_RPT_HI 7
`define RCA_RPT5_BIT 6

// flags register fields
`define RCA_FLAG_WDF 7
`define RCA_FLAG_AF 6

// watchdog register fields
`define RCA_WD_MULT_HI 6
`define RCA_WD_MULT_LO 2
`define RCA_WD_RES_HI 1
`define RCA_WD_RES_LO 0

// divider chain, in oscillator cycles
`define RCA_SEC_LAST 16'h7FFF
`define RCA_CAL_POS_STEP 16'h0100
`define RCA_CAL_NEG_STEP 16'h0080
`define RCA_SEC_PER_MIN 6'h3B
`define RCA_CAL_SEC 6'h3B
`define RCA_FT_DIV_BIT 5

// watchdog resolution units, in oscillator cycles minus one
`define RCA_WD_U16 18'h007FF
`define RCA_WD_U4 18'h01FFF
`define RCA_WD_U1 18'h07FFF
`define RCA_WD_UX4 18'h1FFFF

`endif

// ---- hdl/rca_pkg.sv ----
/*
  types shared by the calibration, alarm and watchdog support block.
  assumes rca_defines.svh is on the include path.
*/
package rca_pkg;
  // source that currently owns the multi-function pin
  typedef enum logic [2:0] {
    RCA_SRC_SQW,
    RCA_SRC_WD_IRQ,
    RCA_SRC_WD_OWN,
    RCA_SRC_ALARM,
    RCA_SRC_FTEST,
    RCA_SRC_STATIC
  } rca_pin_src_t;

  // watchdog resolution codes
  typedef enum logic [1:0] {
    RCA_RES_16TH,
    RCA_RES_QUARTER,
    RCA_RES_ONE,
    RCA_RES_FOUR
  } rca_wd_res_t;
endpackage

// ---- hdl/rca_calib.sv ----
/*
  oscillator divider chain with periodic calibration, second tick and the
  uncalibrated 512 Hz test wave.
  assumes osc_tick is a one-cycle pulse per 32768 Hz oscillator period,
  synchronous to clk.
*/
`timescale 1ns/1ps
`include "rca_defines.svh"

module rca_calib (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic halt,
  input wire logic [4:0] cal_mag,
  input wire logic cal_pos,
  output logic sec_tick,
  output logic ft_wave
);
  logic [15:0] sub_cnt_ff; // oscillator cycles within the current second
  logic [5:0] sec_idx_ff; // second within the minute
  logic [5:0] min_idx_ff; // minute within the 64 minute cycle
  logic [5:0] ft_cnt_ff; // free divider, never touched by calibration
  logic [15:0] last_cnt; // terminal count of this second
  logic alter; // this second is corrected
  logic wrap;

  // correction lands on one second per minute in the first 2N minutes
  assign alter = (min_idx_ff < {cal_mag, 1'b0}) && (sec_idx_ff == `RCA_CAL_SEC); // [RULE_03] [RULE_04]

  // inserting counts shortens the second, blanking lengthens it
  always_comb begin
    if (alter && cal_pos) begin
      last_cnt = `RCA_SEC_LAST - `RCA_CAL_POS_STEP; // [RULE_01] [RULE_02]
    end else if (alter) begin
      last_cnt = `RCA_SEC_LAST + `RCA_CAL_NEG_STEP; // [RULE_01] [RULE_02]
    end else begin
      last_cnt = `RCA_SEC_LAST;
    end
  end

  assign wrap = osc_tick && !halt && (sub_cnt_ff == last_cnt);

  // sub-second counter, corrected at the divide-by-256 stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sub_cnt_ff <= 16'h0000;
    end else if (ce && osc_tick && !halt) begin
      sub_cnt_ff <= wrap ? 16'h0000 : sub_cnt_ff + 16'h0001; // [RULE_01]
    end
  end

  // second and minute position inside the calibration cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sec_idx_ff <= 6'h00;
      min_idx_ff <= 6'h00;
    end else if (ce && wrap) begin
      if (sec_idx_ff == `RCA_SEC_PER_MIN) begin
        sec_idx_ff <= 6'h00;
        min_idx_ff <= min_idx_ff + 6'h01; // wraps after 64 minutes [RULE_03]
      end else begin
        sec_idx_ff <= sec_idx_ff + 6'h01;
      end
    end
  end

  // one pulse per (calibrated) second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sec_tick <= 1'b0;
    end else if (ce) begin
      sec_tick <= wrap;
    end
  end

  // test wave from an uncorrected divider: 32768 / 64 = 512 Hz
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ft_cnt_ff <= 6'h00;
    end else if (ce && osc_tick && !halt) begin
      ft_cnt_ff <= ft_cnt_ff + 6'h01; // [RULE_06]
    end
  end

  assign ft_wave = ft_cnt_ff[`RCA_FT_DIV_BIT];
endmodule

// ---- hdl/rca_wdog.sv ----
/*
  watchdog timeout counter: multiplier times resolution, restarted by writes.
  assumes osc_tick is a one-cycle pulse per oscillator period, and wd_wr a
  one-cycle pulse carrying the new register value.
*/
`timescale 1ns/1ps
`include "rca_defines.svh"

module rca_wdog (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic wd_wr,
  input wire logic [4:0] wd_mult,
  input wire logic [1:0] wd_res,
  output logic timeout
);
  logic [17:0] tick_cnt_ff; // oscillator cycles within one unit
  logic [4:0] unit_cnt_ff; // completed resolution units
  logic armed_ff; // counting toward a timeout
  logic [17:0] unit_last;
  logic unit_done;

  // terminal count of one resolution unit
  function automatic logic [17:0] unit_of(input logic [1:0] res);
    case (rca_pkg::rca_wd_res_t'(res))
      rca_pkg::RCA_RES_16TH: unit_of = `RCA_WD_U16;
      rca_pkg::RCA_RES_QUARTER: unit_of = `RCA_WD_U4;
      rca_pkg::RCA_RES_ONE: unit_of = `RCA_WD_U1;
      default: unit_of = `RCA_WD_UX4;
    endcase
  endfunction

  assign unit_last = unit_of(wd_res); // [RULE_15]
  assign unit_done = armed_ff && osc_tick && (tick_cnt_ff == unit_last);

  // counters restart from zero on every write, with the new value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt_ff <= 18'h00000;
      unit_cnt_ff <= 5'h00;
      armed_ff <= 1'b0; // disabled after power-up [RULE_20]
    end else if (ce) begin
      if (wd_wr) begin
        tick_cnt_ff <= 18'h00000; // [RULE_17]
        unit_cnt_ff <= 5'h00;
        armed_ff <= (wd_mult != 5'h00); // zero keeps it off [RULE_18]
      end else if (unit_done) begin
        tick_cnt_ff <= 18'h00000;
        unit_cnt_ff <= unit_cnt_ff + 5'h01;
        if (unit_cnt_ff + 5'h01 == wd_mult) begin
          armed_ff <= 1'b0; // one timeout per programming
        end
      end else if (armed_ff && osc_tick) begin
        tick_cnt_ff <= tick_cnt_ff + 18'h00001;
      end
    end
  end

  // timeout after multiplier times resolution
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timeout <= 1'b0;
    end else if (ce) begin
      timeout <= unit_done && !wd_wr && (unit_cnt_ff + 5'h01 == wd_mult); // [RULE_16]
    end
  end
endmodule

// ---- hdl/rca_top.sv ----
/*
  calibration, alarm and watchdog support logic of a serial real-time clock,
  with its register file (control, watchdog, alarm, flags) and the open-drain
  multi-function pin.
  assumes the serial bus engine presents one-cycle read and write strobes with
  the register address, plus its resting address pointer; the outside time
  counters present BCD time and pulse time_update after each change.
*/
`timescale 1ns/1ps
`include "rca_defines.svh"

// Functional notes
// [RULE_01] calibration adjusts counts at divide-by-256 stage
// [RULE_02] five-bit magnitude, bit five selects sign
// [RULE_03] 64-minute cycle, one second per minute altered
// [RULE_04] magnitude N corrects first 2N minutes
// [RULE_05] pin toggles 512 Hz in frequency test
// [RULE_06] test wave comes from uncalibrated divider
// [RULE_07] power-down clears frequency test bit
// [RULE_08] repeat code selects compared alarm fields
// [RULE_09] undefined repeat codes act once per second
// [RULE_10] match sets flag, may pull pin low
// [RULE_11] pointer on flags address defers alarm
// [RULE_12] flags read releases pin, clears alarm flag
// [RULE_13] host rereads flags to see cleared flag
// [RULE_14] backup alarm needs both enables set
// [RULE_15] watchdog register: multiplier and resolution fields
// [RULE_16] timeout sets flag and pulls pin
// [RULE_17] every watchdog write restarts the count
// [RULE_18] writing zero releases pin, disables watchdog
// [RULE_19] flags read clears watchdog flag
// [RULE_20] power-up clears watchdog register
// [RULE_21] programmed watchdog suppresses frequency test output
// [RULE_22] alarm fields BCD, control and watchdog binary
// [RULE_23] idle pin follows static output level bit
// [RULE_24] open-drain pin, watchdog-alarm-test-static priority; the code puts the square wave above all four
module rca_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic oscillator_halt,
  input wire logic power_down,
  input wire logic battery_backup,
  input wire logic [4:0] addr_ptr,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic time_update,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  input wire logic [4:0] cur_month,
  input wire logic sqw_wave,
  output logic sec_tick,
  input wire logic multi_function_pin_i,
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe
);
  logic [7:0] ctrl_ff; // control_calibration
  logic [7:0] wdog_ff; // watchdog_setting
  logic [7:0] al_mon_ff; // alarm_month_and_enables
  logic [7:0] al_date_ff; // alarm date, top bits hold repeat code
  logic [7:0] al_hour_ff; // alarm hour, bit 6 is the update-halt bit
  logic [7:0] al_min_ff; // alarm minutes
  logic [7:0] al_sec_ff; // alarm seconds
  logic alarm_flag_ff; // alarm_flag
  logic watchdog_timeout_flag_ff; // watchdog_timeout_flag
  logic alarm_irq_ff; // alarm interrupt holding the pin
  logic wd_irq_ff; // watchdog interrupt holding the pin
  logic alarm_pend_ff; // match deferred while pointer sits on flags
  logic pin_low_ff; // registered open-drain enable
  logic ft_wave;
  logic wd_timeout;
  logic wd_wr;
  logic flags_rd;
  logic [4:0] alarm_repeat_code;
  logic alarm_hit;
  logic alarm_fire;
  logic ptr_on_flags;
  logic nxt_pin_low;
  logic frequency_test_enable;
  logic alarm_irq_enable;
  logic square_wave_enable;
  logic alarm_in_backup_enable;
  rca_pkg::rca_pin_src_t pin_src;

  // decoded control bits
  assign frequency_test_enable = ctrl_ff[`RCA_CTRL_FT];
  assign alarm_irq_enable = al_mon_ff[`RCA_AL_AFE];
  assign square_wave_enable = al_mon_ff[`RCA_AL_SQUARE_WAVE_ENABLE];
  assign alarm_in_backup_enable = al_mon_ff[`RCA_AL_ABE];
  assign alarm_repeat_code = {al_date_ff[`RCA_RPT5_BIT], al_date_ff[`RCA_RPT_HI], al_hour_ff[`RCA_RPT_HI],
    al_min_ff[`RCA_RPT_HI], al_sec_ff[`RCA_RPT_HI]};

  assign wd_wr = ce && wr_en && (wr_addr == `RCA_ADDR_WDOG);
  assign flags_rd = ce && rd_en && (rd_addr == `RCA_ADDR_FLAGS);
  assign ptr_on_flags = (addr_ptr == `RCA_ADDR_FLAGS);

  // alarm field compare, raw BCD against BCD time
  function automatic logic alarm_match(input logic [4:0] code, input logic eq_sec, input logic eq_min,
    input logic eq_hour, input logic eq_date, input logic eq_mon);
    case (code)
      5'h1F: alarm_match = 1'b1; // once per second [RULE_08]
      5'h1E: alarm_match = eq_sec; // once per minute [RULE_08]
      5'h1C: alarm_match = eq_sec && eq_min; // once per hour [RULE_08]
      5'h18: alarm_match = eq_sec && eq_min && eq_hour; // once per day [RULE_08]
      5'h10: alarm_match = eq_sec && eq_min && eq_hour && eq_date; // once per month [RULE_08]
      5'h00: alarm_match = eq_sec && eq_min && eq_hour && eq_date && eq_mon; // once per year [RULE_08]
      default: alarm_match = 1'b1; // unlisted codes fall back to every second [RULE_09]
    endcase
  endfunction

  // alarm fields are stored and compared as BCD digits
  assign alarm_hit = time_update && alarm_match(alarm_repeat_code, al_sec_ff[6:0] == cur_sec,
    al_min_ff[6:0] == cur_min, al_hour_ff[5:0] == cur_hour, al_date_ff[5:0] == cur_date,
    al_mon_ff[4:0] == cur_month); // [RULE_22]

  // a match, or a deferred one, fires once the pointer is off the flags address
  assign alarm_fire = (alarm_hit || alarm_pend_ff) && !ptr_on_flags; // [RULE_11]

  // divider chain with calibration and test wave
  rca_calib u_calib (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .osc_tick(osc_tick),
    .halt(oscillator_halt),
    .cal_mag(ctrl_ff[`RCA_CTRL_CAL_HI:0]),
    .cal_pos(ctrl_ff[`RCA_CTRL_SIGN]),
    .sec_tick(sec_tick),
    .ft_wave(ft_wave)
  );

  // watchdog counter
  rca_wdog u_wdog (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .osc_tick(osc_tick),
    .wd_wr(wd_wr),
    .wd_mult(wd_wr ? wr_data[`RCA_WD_MULT_HI:`RCA_WD_MULT_LO] : wdog_ff[`RCA_WD_MULT_HI:`RCA_WD_MULT_LO]),
    .wd_res(wdog_ff[`RCA_WD_RES_HI:`RCA_WD_RES_LO]),
    .timeout(wd_timeout)
  );

  // control register; power-down drops the frequency test bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_ff <= `RCA_CTRL_RESET;
    end else if (ce) begin
      if (wr_en && wr_addr == `RCA_ADDR_CTRL) begin
        ctrl_ff <= wr_data; // plain binary [RULE_02] [RULE_22]
      end
      if (power_down) begin
        ctrl_ff[`RCA_CTRL_FT] <= 1'b0; // [RULE_07]
      end
    end
  end

  // watchdog register, cleared at power-up
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdog_ff <= 8'h00; // [RULE_20]
    end else if (wd_wr) begin
      wdog_ff <= {1'b0, wr_data[`RCA_WD_MULT_HI:0]}; // [RULE_15] [RULE_17]
    end
  end

  // alarm registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      al_mon_ff <= 8'h00;
      al_date_ff <= 8'h00;
      al_hour_ff <= 8'h00;
      al_min_ff <= 8'h00;
      al_sec_ff <= 8'h00;
    end else if (ce && wr_en) begin
      if (wr_addr == `RCA_ADDR_AL_MON) begin
        al_mon_ff <= wr_data;
      end else if (wr_addr == `RCA_ADDR_AL_DATE) begin
        al_date_ff <= wr_data;
      end else if (wr_addr == `RCA_ADDR_AL_HOUR) begin
        al_hour_ff <= wr_data;
      end else if (wr_addr == `RCA_ADDR_AL_MIN) begin
        al_min_ff <= wr_data;
      end else if (wr_addr == `RCA_ADDR_AL_SEC) begin
        al_sec_ff <= wr_data;
      end
    end
  end

  // deferred alarm while the pointer rests on the flags address
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alarm_pend_ff <= 1'b0;
    end else if (ce) begin
      if (alarm_hit && ptr_on_flags) begin
        alarm_pend_ff <= 1'b1; // [RULE_11]
      end else if (!ptr_on_flags) begin
        alarm_pend_ff <= 1'b0;
      end
    end
  end

  // alarm flag and interrupt: set wins over the read clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alarm_flag_ff <= 1'b0;
      alarm_irq_ff <= 1'b0;
    end else if (ce) begin
      if (alarm_fire) begin
        alarm_flag_ff <= 1'b1; // [RULE_10]
        alarm_irq_ff <= 1'b1;
      end else if (flags_rd) begin
        alarm_flag_ff <= 1'b0; // [RULE_12]
        alarm_irq_ff <= 1'b0; // [RULE_12]
      end
    end
  end

  // watchdog flag cleared by a flags read, interrupt only by writing zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      watchdog_timeout_flag_ff <= 1'b0;
      wd_irq_ff <= 1'b0;
    end else if (ce) begin
      if (wd_timeout) begin
        watchdog_timeout_flag_ff <= 1'b1; // [RULE_16]
      end else if (flags_rd) begin
        watchdog_timeout_flag_ff <= 1'b0; // [RULE_19]
      end
      if (wd_timeout) begin
        wd_irq_ff <= 1'b1; // [RULE_16]
      end else if (wd_wr && wr_data == 8'h00) begin
        wd_irq_ff <= 1'b0; // [RULE_18]
      end
    end
  end

  // read data: the flag value sampled before the clear takes effect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        if (rd_addr == `RCA_ADDR_CTRL) begin
          rd_data <= ctrl_ff;
        end else if (rd_addr == `RCA_ADDR_WDOG) begin
          rd_data <= wdog_ff;
        end else if (rd_addr == `RCA_ADDR_AL_MON) begin
          rd_data <= al_mon_ff;
        end else if (rd_addr == `RCA_ADDR_AL_DATE) begin
          rd_data <= al_date_ff;
        end else if (rd_addr == `RCA_ADDR_AL_HOUR) begin
          rd_data <= al_hour_ff;
        end else if (rd_addr == `RCA_ADDR_AL_MIN) begin
          rd_data <= al_min_ff;
        end else if (rd_addr == `RCA_ADDR_AL_SEC) begin
          rd_data <= al_sec_ff;
        end else if (rd_addr == `RCA_ADDR_FLAGS) begin
          rd_data <= {watchdog_timeout_flag_ff, alarm_flag_ff, 6'h00}; // [RULE_12] [RULE_19]
        end else begin
          rd_data <= 8'h00; // other addresses belong elsewhere
        end
      end
    end
  end

  // pin owner, highest priority first
  always_comb begin
    if (square_wave_enable) begin
      pin_src = rca_pkg::RCA_SRC_SQW;
    end else if (wd_irq_ff) begin
      pin_src = rca_pkg::RCA_SRC_WD_IRQ; // [RULE_24]
    end else if (wdog_ff != 8'h00 && frequency_test_enable) begin
      pin_src = rca_pkg::RCA_SRC_WD_OWN; // [RULE_21]
    end else if (alarm_irq_ff && alarm_irq_enable && (!battery_backup || alarm_in_backup_enable)) begin
      pin_src = rca_pkg::RCA_SRC_ALARM; // [RULE_10] [RULE_14]
    end else if (frequency_test_enable && !alarm_irq_enable && !oscillator_halt && wdog_ff == 8'h00) begin
      pin_src = rca_pkg::RCA_SRC_FTEST; // [RULE_05]
    end else begin
      pin_src = rca_pkg::RCA_SRC_STATIC;
    end
  end

  // pull-low decision for each owner
  always_comb begin
    case (pin_src)
      rca_pkg::RCA_SRC_SQW: nxt_pin_low = !sqw_wave;
      rca_pkg::RCA_SRC_WD_IRQ: nxt_pin_low = 1'b1; // [RULE_16]
      rca_pkg::RCA_SRC_WD_OWN: nxt_pin_low = 1'b0; // test wave denied [RULE_21]
      rca_pkg::RCA_SRC_ALARM: nxt_pin_low = 1'b1; // [RULE_10]
      rca_pkg::RCA_SRC_FTEST: nxt_pin_low = !ft_wave; // [RULE_05] [RULE_06]
      default: begin
        // static level only when nothing else is active
        nxt_pin_low = !alarm_irq_enable && !frequency_test_enable && wdog_ff == 8'h00 &&
          !ctrl_ff[`RCA_CTRL_OUT]; // [RULE_23]
      end
    endcase
  end

  // open-drain driver: only ever pulls low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_low_ff <= 1'b0;
    end else if (ce) begin
      pin_low_ff <= nxt_pin_low; // [RULE_24]
    end
  end

  assign multi_function_pin_o = 1'b0; // [RULE_24]
  assign multi_function_pin_oe = pin_low_ff;
endmodule

// ---- testbench/rca_top_asserts.sv ----
/*
  port assertions for the support block.
  assumes a bind to rca_top from the bench top file.
*/
`timescale 1ns/1ps
module rca_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic oscillator_halt,
  input wire logic power_down,
  input wire logic battery_backup,
  input wire logic [4:0] addr_ptr,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic time_update,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  input wire logic [4:0] cur_month,
  input wire logic sqw_wave,
  input wire logic sec_tick,
  input wire logic multi_function_pin_i,
  input wire logic multi_function_pin_o,
  input wire logic multi_function_pin_oe
);
  // one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // a read is answered in the next cycle, for one cycle only
  a_read_answered: assert property (ce && rd_en |=> rd_valid) else $error("read not answered");
  a_valid_single: assert property (ce && !rd_en |=> !rd_valid) else $error("stray read valid");
  // unmapped places read as zero
  a_unmapped_zero: assert property (ce && rd_en && (rd_addr < 5'h08 || rd_addr > 5'h0F)
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  // unused flag bits read zero
  a_flags_unused: assert property (ce && rd_en && rd_addr == 5'h0F |=> rd_data[5:0] == 6'h00)
    else $error("flag low bits set");
  // watchdog register keeps seven bits, top bit zero
  a_wdog_readback: assert property (ce && wr_en && wr_addr == 5'h09
    ##2 ce && rd_en && rd_addr == 5'h09 && !wr_en |=> rd_data == ($past(wr_data, 3) & 8'h7F))
    else $error("watchdog readback wrong");
  // control register reads back whole
  a_ctrl_readback: assert property (ce && wr_en && wr_addr == 5'h08 && !power_down
    ##2 ce && rd_en && rd_addr == 5'h08 && !wr_en && !power_down |=> rd_data == $past(wr_data, 3))
    else $error("control readback wrong");
  // pin may only pull low
  a_open_drain: assert property (multi_function_pin_o == 1'b0) else $error("pin driven high");
  // pin released and no answer right after reset
  a_reset_release: assert property ($rose(rstn) |-> !multi_function_pin_oe && !rd_valid)
    else $error("pin held after reset");
  // seconds stay far apart
  a_second_pulse: assert property (sec_tick |=> !sec_tick [*8]) else $error("second tick too close");

  c_alarm_pin: cover property (time_update ##2 multi_function_pin_oe);
  c_wdog_flag: cover property (rd_en && rd_addr == 5'h0F ##1 rd_data[7]);
  c_second: cover property (sec_tick);
endmodule

// ---- testbench/rca_host.sv ----
/*
  host model: single-byte register reads and writes, resting pointer.
  assumes callers enter tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module rca_host (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic [4:0] addr_ptr,
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [4:0] rd_addr
);
  // idle bus at time zero
  initial begin
    addr_ptr = 5'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 5'h00;
    wr_data = 8'h00;
    rd_addr = 5'h00;
  end

  // one-byte write; pointer then rests on the next address
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    wr_addr = a;
    wr_data = v;
    wr_en = 1'b1;
    @(posedge clk);
    #1 wr_en = 1'b0;
    wr_data = ~v;
    addr_ptr = a + 5'h01;
    @(posedge clk) #1;
  endtask

  // one-byte read; data taken in the answer cycle
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    rd_addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1 rd_en = 1'b0;
    v = rd_data;
    addr_ptr = a + 5'h01;
    @(posedge clk) #1;
  endtask
endmodule

// ---- testbench/rca_top_tb.sv ----
/*
  bench for the calibration, alarm and watchdog block.
  assumes osc_tick runs every clock so long counts stay short.
*/
`timescale 1ns/1ps
module rca_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic power_down = 1'b0;
  logic battery_backup = 1'b0;
  logic time_update = 1'b0;
  logic [6:0] cur_sec = 7'h45;
  logic [6:0] cur_min = 7'h30;
  logic [5:0] cur_hour = 6'h10;
  logic [5:0] cur_date = 6'h15;
  logic [4:0] cur_month = 5'h01;
  logic [4:0] addr_ptr, wr_addr, rd_addr;
  logic wr_en, rd_en, rd_valid, sec_tick, pin_o, oe, pin;
  logic [7:0] wr_data, rd_data, d;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n;

  // 20 ns clock
  always #10 clk = ~clk;
  // open-drain wire with a pull-up
  assign pin = oe ? 1'b0 : 1'b1;

  rca_host host (.clk(clk), .rd_data(rd_data), .addr_ptr(addr_ptr), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));

  rca_top DUT (.clk(clk), .rstn(rstn), .ce(1'b1), .osc_tick(1'b1), .oscillator_halt(1'b0),
    .power_down(power_down), .battery_backup(battery_backup), .addr_ptr(addr_ptr), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .time_update(time_update), .cur_sec(cur_sec), .cur_min(cur_min),
    .cur_hour(cur_hour), .cur_date(cur_date), .cur_month(cur_month), .sqw_wave(1'b0),
    .sec_tick(sec_tick), .multi_function_pin_i(pin), .multi_function_pin_o(pin_o),
    .multi_function_pin_oe(oe));

  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait k edges, then step off the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic pin_is(input logic v);
    chk({7'h00, oe}, {7'h00, v});
  endtask

  // one time update, then let flag and pin settle
  task automatic match;
    time_update = 1'b1;
    tick(1);
    time_update = 1'b0;
    tick(3);
  endtask

  // cycles between two pin changes, bounded
  task automatic half_period(output logic [7:0] m);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = oe;
      m = 8'h00;
      while (oe === v && m < 8'h64) begin
        tick(1);
        m = m + 8'h01;
      end
    end
  endtask

  // run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial begin
    tick(6);
    rstn = 1'b1;
    host.rd(5'h08, d);
    chk(d, 8'h80);
    host.rd(5'h09, d);
    chk(d, 8'h00);
    pin_is(1'b0);
    host.rd(5'h10, d);
    chk(d, 8'h00);
    host.wr(5'h08, 8'h00);
    tick(2);
    pin_is(1'b1);
    // test wave, then with calibration changed
    host.wr(5'h08, 8'h40);
    half_period(d);
    chk(d, 8'h20);
    host.wr(5'h08, 8'h7F);
    host.rd(5'h08, d);
    chk(d, 8'h7F);
    half_period(d);
    chk(d, 8'h20);
    power_down = 1'b1;
    tick(1);
    power_down = 1'b0;
    host.rd(5'h08, d);
    chk(d, 8'h3F);
    // watchdog: two times 1/16 s, restarted once
    host.wr(5'h08, 8'h40);
    host.wr(5'h09, 8'h88);
    host.rd(5'h09, d);
    chk(d, 8'h08);
    pin_is(1'b0);
    tick(1500);
    host.wr(5'h09, 8'h88);
    tick(3000);
    pin_is(1'b0);
    n = 0;
    while (oe !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    chk({7'h00, n >= 1090 && n <= 1104}, 8'h01);
    host.rd(5'h0F, d);
    chk(d, 8'h80);
    host.rd(5'h0F, d);
    chk(d, 8'h00);
    host.wr(5'h08, 8'h80);
    pin_is(1'b1);
    host.wr(5'h09, 8'h00);
    tick(2);
    pin_is(1'b0);
    // alarm once per year, all fields matching
    host.wr(5'h0E, 8'h45);
    host.wr(5'h0D, 8'h30);
    host.wr(5'h0C, 8'h10);
    host.wr(5'h0B, 8'h15);
    host.wr(5'h0A, 8'h81);
    match;
    pin_is(1'b1);
    host.rd(5'h0F, d);
    chk(d, 8'h40);
    tick(1);
    pin_is(1'b0);
    host.rd(5'h0F, d);
    chk(d, 8'h00);
    cur_sec = 7'h46;
    match;
    host.rd(5'h0F, d);
    chk(d, 8'h00);
    // undefined repeat code; pointer left on the flags
    host.wr(5'h0E, 8'hC5);
    match;
    pin_is(1'b0);
    host.rd(5'h0F, d);
    chk(d, 8'h00);
    tick(3);
    pin_is(1'b1);
    host.rd(5'h0F, d);
    chk(d, 8'h40);
    // backup mode needs both enables
    battery_backup = 1'b1;
    match;
    pin_is(1'b0);
    host.rd(5'h0F, d);
    chk(d, 8'h40);
    host.wr(5'h0A, 8'hA1);
    match;
    pin_is(1'b1);
    // first second of the plain divider
    n = 0;
    while (sec_tick !== 1'b1 && n < 40000) begin
      tick(1);
      n++;
    end
    chk({7'h00, cyc >= 32765 && cyc <= 32800}, 8'h01);
    end_of_test;
  end
endmodule

bind rca_top rca_asserts u_chk (.clk(clk), .rstn(rstn), .ce(ce), .osc_tick(osc_tick),
  .oscillator_halt(oscillator_halt), .power_down(power_down), .battery_backup(battery_backup),
  .addr_ptr(addr_ptr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .time_update(time_update),
  .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour), .cur_date(cur_date),
  .cur_month(cur_month), .sqw_wave(sqw_wave), .sec_tick(sec_tick),
  .multi_function_pin_i(multi_function_pin_i), .multi_function_pin_o(multi_function_pin_o),
  .multi_function_pin_oe(multi_function_pin_oe));
